//--- core/rotdp_params.svh
// constants of the file-register rotate datapath
// assumes one 20 MHz clock and an axi4-lite register bus
//
// Contract
// - rotate left without carry moves bit 7 to bit 0 and updates only n and z.
// - rotate right through carry puts old bit 0 in c, old c in bit 7, updates c, n, z.
// - rotate right without carry wraps bit 0 into bit 7 and leaves c alone.
// - destination bit 0 writes the working register, 1 writes the file register.
// - access bit 0 uses the fixed access bank, 1 uses the bank select register.
// - each rotate is one word: low byte is the file address, opcode, d and a above.
// - each rotate takes one cycle of four phases: decode, read, process, write.
`ifndef ROTDP_PARAMS_SVH
`define ROTDP_PARAMS_SVH

`define ADDR_W 12
`define DATA_W 32
`define OFS_INSTR 12'h000
`define OFS_STATUS 12'h004
`define OFS_WREG 12'h008
`define OFS_BANKSEL 12'h00c
`define MEM_SEL_BIT 11
`define MEM_IDX_HI 10
`define MEM_IDX_LO 2
`define MEM_DEPTH 512
`define IDX_W 9
`define BANK_SEL_W 4
`define ACCESS_BANK 1'h0
`define ST_C 0
`define ST_Z 2
`define ST_N 4
`define ST_BUSY 8
`define ST_BADOP 9
`define OPC_RLNC 6'h11
`define OPC_RRC 6'h0c
`define OPC_RRNC 6'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define INSTR_RST 16'h0000

`endif

//--- core/rotdp_pkg.sv
// types of the file-register rotate datapath
// assumes the constants header is included by the core
package rotdp_pkg;

    // execution phases of one instruction cycle
    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_DEC = 3'h1,
        PH_RD = 3'h2,
        PH_PROC = 3'h3,
        PH_WR = 3'h4
    } rotdp_phase_t;

    // one program word of a file-register instruction
    typedef struct packed {
        logic [5:0] opc;
        logic dst;
        logic acc;
        logic [7:0] fadr;
    } rotdp_instr_t;

    // arithmetic flags touched by the rotates
    typedef struct packed {
        logic n;
        logic z;
        logic c;
    } rotdp_flags_t;

endpackage

//--- core/rotdp_core.sv
// rotate datapath: executes three file-register rotates over a flop memory
// assumes an axi4-lite master on the same clock; no pin synchronisers needed
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "rotdp_params.svh"
`default_nettype none
module rotdp_core
    import rotdp_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [`DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read address and data
    input wire logic arvalid,
    output logic arready,
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [`DATA_W-1:0] rdata,
    output logic [1:0] rresp
);

    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [`DATA_W-1:0] rdata_ff;
    logic aw_hold_ff, w_hold_ff;
    logic nxt_aw_hold, nxt_w_hold;
    logic [`ADDR_W-1:0] awaddr_ff;
    logic [`DATA_W-1:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic do_wr, aw_fire, w_fire, ar_fire, instr_go;
    rotdp_phase_t ph_ff;
    rotdp_instr_t ir_ff, dec_ff;
    rotdp_flags_t flg_ff, nxt_flg;
    logic badop_ff;
    logic [7:0] wreg_ff, opnd_ff, res_ff;
    logic cnew_ff;
    logic [`BANK_SEL_W-1:0] bank_select_register_ff;
    logic [7:0] mem_ff [`MEM_DEPTH];
    logic [`IDX_W-1:0] exec_idx;
    logic dec_rot;

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    // merge a byte-enabled write into a 16-bit register image
    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [`DATA_W-1:0] d, input logic [3:0] s);
        merge16 = old;
        if (s[0])
        begin
            merge16[7:0] = d[7:0];
        end
        if (s[1])
        begin
            merge16[15:8] = d[15:8];
        end
    endfunction

    // true for one of the three rotate opcodes
    function automatic logic is_rot(input logic [5:0] opc);
        is_rot = (opc == `OPC_RLNC) || (opc == `OPC_RRC) ||
            (opc == `OPC_RRNC);
    endfunction

    // decode of the register map, shared by read and write paths
    function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
        is_mapped = a[`MEM_SEL_BIT] || (a == `OFS_INSTR) ||
            (a == `OFS_STATUS) || (a == `OFS_WREG) ||
            (a == `OFS_BANKSEL);
    endfunction

    // rotate unit: returns {carry out, result}
    function automatic logic [8:0] rotate(input logic [5:0] opc,
        input logic [7:0] v, input logic cin);
        case (opc)
            `OPC_RLNC: rotate = {cin, v[6:0], v[7]};
            `OPC_RRC: rotate = {v[0], cin, v[7:1]};
            `OPC_RRNC: rotate = {cin, v[0], v[7:1]};
            default: rotate = {cin, v};
        endcase
    endfunction

    assign aw_fire = awvalid && awready_ff;
    assign w_fire = wvalid && wready_ff;
    assign ar_fire = arvalid && arready_ff;
    // bus writes wait while an instruction runs, so no flop has two writers
    assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff &&
        (ph_ff == PH_IDLE);
    assign instr_go = do_wr && (awaddr_ff == `OFS_INSTR) && wstrb_ff[0];
    assign dec_rot = is_rot(dec_ff.opc);
    // bank choice: access bank or the bank select register
    assign exec_idx = {dec_ff.acc ? bank_select_register_ff[0] :
        `ACCESS_BANK, dec_ff.fadr};

    // address and data are taken in either order and held until used
    always_comb
    begin
        nxt_aw_hold = aw_hold_ff;
        nxt_w_hold = w_hold_ff;
        if (aw_fire)
        begin
            nxt_aw_hold = 1'b1;
        end
        else if (do_wr)
        begin
            nxt_aw_hold = 1'b0;
        end
        if (w_fire)
        begin
            nxt_w_hold = 1'b1;
        end
        else if (do_wr)
        begin
            nxt_w_hold = 1'b0;
        end
    end

    // write channels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end
        else
        begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            awready_ff <= !nxt_aw_hold;
            wready_ff <= !nxt_w_hold;
            if (aw_fire)
            begin
                awaddr_ff <= awaddr;
            end
            if (w_fire)
            begin
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (do_wr)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= is_mapped(awaddr_ff) ? `RESP_OKAY :
                    `RESP_SLVERR;
            end
            else if (bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= `RESP_OKAY;
        end
        else if (ar_fire)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
            rdata_ff <= '0;
            if (araddr[`MEM_SEL_BIT])
            begin
                rdata_ff[7:0] <= mem_ff[araddr[`MEM_IDX_HI:`MEM_IDX_LO]];
            end
            else
            begin
                case (araddr)
                    `OFS_INSTR: rdata_ff[15:0] <= ir_ff;
                    `OFS_STATUS:
                    begin
                        rdata_ff[`ST_C] <= flg_ff.c;
                        rdata_ff[`ST_Z] <= flg_ff.z;
                        rdata_ff[`ST_N] <= flg_ff.n;
                        rdata_ff[`ST_BUSY] <= (ph_ff != PH_IDLE);
                        rdata_ff[`ST_BADOP] <= badop_ff;
                    end
                    `OFS_WREG: rdata_ff[7:0] <= wreg_ff;
                    `OFS_BANKSEL: rdata_ff[`BANK_SEL_W-1:0] <=
                        bank_select_register_ff;
                    default: rdata_ff <= '0;
                endcase
            end
        end
        else if (rvalid_ff && rready)
        begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
        else if (!rvalid_ff)
        begin
            arready_ff <= 1'b1;
        end
    end

    // phase sequencer: one instruction cycle of four phases
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph_ff <= PH_IDLE;
        end
        else
        begin
            case (ph_ff)
                PH_IDLE: ph_ff <= instr_go ? PH_DEC : PH_IDLE;
                PH_DEC: ph_ff <= PH_RD;
                PH_RD: ph_ff <= PH_PROC;
                PH_PROC: ph_ff <= PH_WR;
                default: ph_ff <= PH_IDLE;
            endcase
        end
    end

    // instruction word and its decoded fields
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ir_ff <= `INSTR_RST;
            dec_ff <= `INSTR_RST;
        end
        else
        begin
            if (instr_go)
            begin
                ir_ff <= merge16(ir_ff, wdata_ff, wstrb_ff);
            end
            if (ph_ff == PH_DEC)
            begin
                dec_ff <= ir_ff;
            end
        end
    end

    // operand read and processing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            opnd_ff <= 8'h00;
            res_ff <= 8'h00;
            cnew_ff <= 1'b0;
        end
        else
        begin
            if (ph_ff == PH_RD)
            begin
                opnd_ff <= mem_ff[exec_idx];
            end
            if (ph_ff == PH_PROC)
            begin
                {cnew_ff, res_ff} <= rotate(dec_ff.opc, opnd_ff, flg_ff.c);
            end
        end
    end

    // file registers: written by software or by the write phase
    always_ff @(posedge aclk)
    begin
        if (do_wr && awaddr_ff[`MEM_SEL_BIT] && wstrb_ff[0])
        begin
            mem_ff[awaddr_ff[`MEM_IDX_HI:`MEM_IDX_LO]] <= wdata_ff[7:0];
        end
        else if (ph_ff == PH_WR && dec_rot && dec_ff.dst)
        begin
            mem_ff[exec_idx] <= res_ff;
        end
    end

    // working register and bank select register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wreg_ff <= 8'h00;
            bank_select_register_ff <= '0;
        end
        else
        begin
            if (do_wr && awaddr_ff == `OFS_WREG && wstrb_ff[0])
            begin
                wreg_ff <= wdata_ff[7:0];
            end
            else if (ph_ff == PH_WR && dec_rot && !dec_ff.dst)
            begin
                wreg_ff <= res_ff;
            end
            if (do_wr && awaddr_ff == `OFS_BANKSEL && wstrb_ff[0])
            begin
                bank_select_register_ff <= wdata_ff[`BANK_SEL_W-1:0];
            end
        end
    end

    // flags after the write phase; carry only for the through-carry rotate
    always_comb
    begin
        nxt_flg.n = res_ff[7];
        nxt_flg.z = (res_ff == 8'h00);
        nxt_flg.c = (dec_ff.opc == `OPC_RRC) ? cnew_ff : flg_ff.c;
    end

    // status flags; a bad opcode is sticky, set beats a software clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flg_ff <= '0;
            badop_ff <= 1'b0;
        end
        else
        begin
            if (ph_ff == PH_WR && dec_rot)
            begin
                flg_ff <= nxt_flg;
            end
            else if (do_wr && awaddr_ff == `OFS_STATUS && wstrb_ff[0])
            begin
                flg_ff.c <= wdata_ff[`ST_C];
                flg_ff.z <= wdata_ff[`ST_Z];
                flg_ff.n <= wdata_ff[`ST_N];
            end
            if (ph_ff == PH_DEC && !is_rot(ir_ff.opc))
            begin
                badop_ff <= 1'b1;
            end
            else if (do_wr && awaddr_ff == `OFS_STATUS && wstrb_ff[1] &&
                wdata_ff[`ST_BADOP])
            begin
                badop_ff <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_start;
        ph_ff == PH_IDLE && instr_go;
    endsequence
    sequence s_phases;
        ph_ff == PH_DEC ##1 ph_ff == PH_RD ##1 ph_ff == PH_PROC
            ##1 ph_ff == PH_WR ##1 ph_ff == PH_IDLE;
    endsequence

    a_four_phase:
        assert property (s_start |=> s_phases)
        else $error("instruction did not run four phases");
    a_rlnc_result:
        assert property (ph_ff == PH_WR && dec_ff.opc == `OPC_RLNC |->
            res_ff == {$past(opnd_ff[6:0]), $past(opnd_ff[7])}
            ##1 flg_ff.c == $past(flg_ff.c))
        else $error("left rotate wrong or carry touched");
    a_rrc_carry:
        assert property (ph_ff == PH_WR && dec_ff.opc == `OPC_RRC |=>
            flg_ff.c == $past(opnd_ff[0], 2) &&
            res_ff[7] == $past(flg_ff.c, 3))
        else $error("carry rotate mishandled carry");
    a_rrnc_wrap:
        assert property (ph_ff == PH_WR && dec_ff.opc == `OPC_RRNC |=>
            flg_ff.c == $past(flg_ff.c) &&
            res_ff == {$past(opnd_ff[0], 2), $past(opnd_ff[7:1], 2)})
        else $error("right rotate wrong or carry touched");
    a_dest_wreg:
        assert property (ph_ff == PH_WR && dec_rot && !dec_ff.dst |=>
            wreg_ff == $past(res_ff))
        else $error("working register not written");
    a_dest_file:
        assert property (ph_ff == PH_WR && dec_rot && dec_ff.dst |=>
            mem_ff[$past(exec_idx)] == $past(res_ff) &&
            wreg_ff == $past(wreg_ff))
        else $error("file register not written");
    a_bank_pick:
        assert property (ph_ff == PH_RD |=>
            opnd_ff == mem_ff[{$past(dec_ff.acc) ?
            $past(bank_select_register_ff[0]) : `ACCESS_BANK,
            $past(dec_ff.fadr)}])
        else $error("operand read from wrong bank");
    a_word_fields:
        assert property (s_start |=> ##1 dec_ff.fadr == ir_ff[7:0] &&
            dec_ff.opc == ir_ff[15:10])
        else $error("instruction fields misdecoded");
    a_nz_flags:
        assert property (ph_ff == PH_WR && dec_rot |=>
            flg_ff.n == $past(res_ff[7]) &&
            flg_ff.z == ($past(res_ff) == 8'h00))
        else $error("n or z flag wrong");

endmodule
`default_nettype wire

//--- verif/rotate_instruction_datapath_test.sv
// self-checking bench for the rotate datapath over its axi4-lite port
// assumes rotdp_core, its package and constants header on the include path
`timescale 1ns/1ps
`include "rotdp_params.svh"
`default_nettype none
module rotate_instruction_datapath_test
    import rotdp_pkg::*;
;

    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [`ADDR_W-1:0] awaddr, araddr;
    logic [`DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [1:0] br_q[$];
    logic [33:0] rd_q[$];
    int n_errors, cmp_count, i;
    logic [5:0] op;
    logic [5:0] ops[3] = '{`OPC_RLNC, `OPC_RRC, `OPC_RRNC};
    logic [7:0] v0, v1, w, f, src;
    logic [8:0] r;
    logic [3:0] bs;
    logic [2:0] fl;
    logic d, a, bk;

    rotdp_core dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp));

    // 20 MHz clock
    always #25 aclk = ~aclk;

    task automatic wrap_up;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
        begin
            cmp_count++;
            if (g !== e)
            begin
                n_errors++;
                $display("wrong value t=%0t exp %h got %h", $time, e, g);
            end
        end
    endtask

    task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
        begin
            cmp_count++;
            if (g !== e)
            begin
                n_errors++;
                $display("wrong value t=%0t exp %h got %h", $time, e, g);
            end
        end
    endtask

    // a hang counts as a mismatch and ends the run at once
    task automatic hang;
        begin
            n_errors++;
            wrap_up();
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] ad, input logic [31:0] dt,
                      input logic [3:0] sb, input logic [1:0] er);
        int n;
        begin
            @(posedge aclk);
            awaddr <= ad;
            wdata <= dt;
            wstrb <= sb;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            br_q.push_back(er);
            for (n = 0; n < 200 && bvalid !== 1'b1; n++)
            begin
                @(posedge aclk);
                if (awvalid && awready === 1'b1)
                    awvalid <= 1'b0;
                if (wvalid && wready === 1'b1)
                    wvalid <= 1'b0;
            end
            if (n == 200)
                hang();
            bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        begin
            @(posedge aclk);
            araddr <= ad;
            arvalid <= 1'b1;
            rready <= 1'b1;
            rd_q.push_back({er, ed});
            for (n = 0; n < 200 && rvalid !== 1'b1; n++)
            begin
                @(posedge aclk);
                if (arvalid && arready === 1'b1)
                    arvalid <= 1'b0;
            end
            if (n == 200)
                hang();
            rready <= 1'b0;
        end
    endtask

    // reads at the edge see pre-edge values, so no race with the flops
    always @(posedge aclk)
    begin
        if (aresetn === 1'b1 && bvalid === 1'b1 && bready === 1'b1)
            cmp_resp(br_q.pop_front(), bresp);
        if (aresetn === 1'b1 && rvalid === 1'b1 && rready === 1'b1)
            cmp_rd(rd_q.pop_front(), {rresp, rdata});
    end

    // expected {carry, result}, worked out independently of the core
    function automatic logic [8:0] rot(input logic [5:0] o,
                                       input logic [7:0] v, input logic c);
        if (o == `OPC_RLNC)
            return {c, v[6:0], v[7]};
        else if (o == `OPC_RRC)
            return {v[0], c, v[7:1]};
        return {c, v[0], v[7:1]};
    endfunction

    function automatic logic [31:0] stw(input logic [2:0] ncz);
        return {27'h0, ncz[2], 1'b0, ncz[1], 1'b0, ncz[0]};
    endfunction

    function automatic logic [11:0] ma(input logic b, input logic [7:0] fa);
        return {1'b1, b, fa, 2'b00};
    endfunction

    function automatic logic [2:0] flg(input logic [8:0] x);
        return {x[7], x[7:0] == 8'h00, x[8]};
    endfunction

    initial
    begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        n_errors = 0;
        cmp_count = 0;
        void'($urandom(58));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // control registers come out of reset cleared
        for (i = 0; i < 4; i++)
            rd(12'(4 * i), 32'h0, `RESP_OKAY);
        // every op with every destination and bank choice
        for (i = 0; i < 12; i++)
        begin
            op = ops[i % 3];
            d = 1'((i / 3) % 2);
            a = 1'((i / 6) % 2);
            v0 = (i == 0) ? 8'h00 : 8'($urandom);
            v1 = 8'($urandom);
            w = 8'($urandom);
            f = 8'($urandom);
            bs = 4'($urandom);
            fl = 3'($urandom);
            bk = a ? bs[0] : `ACCESS_BANK;
            wr(`OFS_BANKSEL, {28'h0, bs}, 4'hf, `RESP_OKAY);
            wr(`OFS_STATUS, stw(fl), 4'hf, `RESP_OKAY);
            wr(ma(1'b0, f), {24'h0, v0}, 4'hf, `RESP_OKAY);
            wr(ma(1'b1, f), {24'h0, v1}, 4'hf, `RESP_OKAY);
            wr(`OFS_WREG, {24'h0, w}, 4'hf, `RESP_OKAY);
            wr(`OFS_INSTR, {16'h0, op, d, a, f}, 4'hf, `RESP_OKAY);
            rd(`OFS_STATUS, stw(fl) | 32'h100, `RESP_OKAY);
            repeat (5) @(posedge aclk);
            src = bk ? v1 : v0;
            r = rot(op, src, fl[0]);
            rd(`OFS_STATUS, stw(flg(r)), `RESP_OKAY);
            rd(`OFS_WREG, {24'h0, d ? w : r[7:0]}, `RESP_OKAY);
            rd(ma(bk, f), {24'h0, d ? r[7:0] : src}, `RESP_OKAY);
            rd(ma(~bk, f), {24'h0, bk ? v0 : v1}, `RESP_OKAY);
        end
        // back to back: the second start stalls until the first is done
        wr(ma(1'b0, 8'h05), 32'h81, 4'hf, `RESP_OKAY);
        wr(`OFS_INSTR, {16'h0, `OPC_RLNC, 2'b10, 8'h05}, 4'hf, `RESP_OKAY);
        wr(`OFS_INSTR, {16'h0, `OPC_RLNC, 2'b10, 8'h05}, 4'hf, `RESP_OKAY);
        repeat (5) @(posedge aclk);
        rd(ma(1'b0, 8'h05), 32'h06, `RESP_OKAY);
        // an unknown opcode leaves data alone and flags the error
        wr(`OFS_STATUS, 32'h0, 4'hf, `RESP_OKAY);
        wr(`OFS_INSTR, {16'h0, 6'h3f, 2'b10, 8'h05}, 4'hf, `RESP_OKAY);
        repeat (5) @(posedge aclk);
        rd(`OFS_STATUS, 32'h200, `RESP_OKAY);
        rd(ma(1'b0, 8'h05), 32'h06, `RESP_OKAY);
        wr(`OFS_STATUS, 32'h200, 4'h2, `RESP_OKAY);
        rd(`OFS_STATUS, 32'h0, `RESP_OKAY);
        // unmapped offset
        wr(12'h010, 32'h5a, 4'hf, `RESP_SLVERR);
        rd(12'h010, 32'h0, `RESP_SLVERR);
        repeat (2) @(posedge aclk);
        wrap_up();
    end
endmodule
`default_nettype wire
